// >>> hw/abmrs_pkg.sv
// package for the bus master request and strobe block
// assumes a single 100 MHz clock and active-low asynchronous reset
package abmrs_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   // least time the strobe stays low in one cycle
   localparam int STROBE_LOW_NS   = 20;
   localparam int STROBE_LOW_CYC  =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STROBE_LOW_CNT = 4'(STROBE_LOW_CYC);
   // ------------------------------------------------------------
   // bus protocol select
   // ------------------------------------------------------------
   localparam logic PROTO_STROBE  = 1'b1;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic RST_HIGH      = 1'b1;
   localparam logic RST_LOW       = 1'b0;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [31:0] RST_ADDR = 32'h0000_0000;
   localparam logic [3:0] RST_CNT  = 4'h0;
   typedef enum logic [2:0] {
      ABMRS_IDLE,
      ABMRS_REQ,
      ABMRS_OWN,
      ABMRS_SETUP,
      ABMRS_STROBE,
      ABMRS_END
   } abmrs_state_t;
endpackage

// >>> hw/abmrs_master.sv
// bus master request, grant acknowledge and cycle strobes
// one memory cycle at a time: request, take the bus, strobe, release
// assumes arbiter and slaves are synchronous to clk; one clock domain
// assumes pads are built outside from the _o and _oe pairs, and that
// the resolved bus levels come back on the _in ports
// Contract
// - address strobe falls only after address and direction outputs are valid.
// - each mastered cycle ends by raising the address strobe.
// - direction line high for whole read cycle, low for whole write.
// - interrupt asserted when any enabled pending source exists.
// - masked pending sources never assert the interrupt.
// - bus request driven low while the bus is needed; the code requests only in strobe protocol mode, until the bus is taken.
// - bus request released to high impedance when not requesting.
// - grant acknowledge used only in the strobe bus protocol mode.
// - take ownership after grant with strobe, acks, grant ack all idle.
module abmrs_master (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        bus_protocol_select,
   input  wire logic        xfer_req,
   input  wire logic        xfer_read,
   input  wire logic [31:0] xfer_addr,
   input  wire logic        xfer_last,
   input  wire logic        bus_grant_n,
   input  wire logic        addr_strobe_n_in,
   input  wire logic        grant_ack_n_in,
   input  wire logic        size_ack_lo_n,
   input  wire logic        size_ack_hi_n,
   input  wire logic [7:0]  irq_status,
   input  wire logic [7:0]  irq_mask,
   output logic             bus_req_n_o,
   output logic             bus_req_n_oe,
   output logic             grant_ack_n_o,
   output logic             grant_ack_n_oe,
   output logic             addr_strobe_n_o,
   output logic             mem_dir_read_high_o,
   output logic [31:0]      addr_o,
   output logic             bus_drive_oe,
   output logic             int_n_o,
   output logic             int_n_oe,
   output logic             xfer_done
);
   abmrs_pkg::abmrs_state_t state_ff;
   abmrs_pkg::abmrs_state_t nxt_state;
   logic [3:0] cnt_ff;
   logic       last_ff;
   logic       bus_free;
   logic       cycle_ack;

   // ------------------------------------------------------------
   // decode shared by the ownership outputs
   // ------------------------------------------------------------
   // true from taking the bus until the tenure ends
   function automatic logic owns_bus(input abmrs_pkg::abmrs_state_t st);
      return st != abmrs_pkg::ABMRS_IDLE && st != abmrs_pkg::ABMRS_REQ;
   endfunction

   // ------------------------------------------------------------
   // arbitration and cycle sequencing
   // ------------------------------------------------------------
   // previous master and slave must be off the bus before taking it
   assign bus_free  = !bus_grant_n && addr_strobe_n_in && grant_ack_n_in
                      && size_ack_lo_n && size_ack_hi_n;
   assign cycle_ack = !size_ack_lo_n && !size_ack_hi_n;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         abmrs_pkg::ABMRS_IDLE: begin
            if (xfer_req && bus_protocol_select == abmrs_pkg::PROTO_STROBE) begin
               nxt_state = abmrs_pkg::ABMRS_REQ;
            end
         end
         abmrs_pkg::ABMRS_REQ: begin
            // grant alone is not ownership; wait for the bus to be idle
            if (bus_free) begin
               nxt_state = abmrs_pkg::ABMRS_OWN;
            end
         end
         abmrs_pkg::ABMRS_OWN: begin
            nxt_state = abmrs_pkg::ABMRS_SETUP;
         end
         abmrs_pkg::ABMRS_SETUP: begin
            nxt_state = abmrs_pkg::ABMRS_STROBE;
         end
         abmrs_pkg::ABMRS_STROBE: begin
            if (cnt_ff == 4'h0 && cycle_ack) begin
               nxt_state = abmrs_pkg::ABMRS_END;
            end
         end
         abmrs_pkg::ABMRS_END: begin
            // back-to-back cycle unless this was the last or the user let go
            if (last_ff || !xfer_req) begin
               nxt_state = abmrs_pkg::ABMRS_IDLE;
            end else begin
               nxt_state = abmrs_pkg::ABMRS_SETUP;
            end
         end
         default: begin
            nxt_state = abmrs_pkg::ABMRS_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // state and strobe width counter
   // ------------------------------------------------------------
   // pins below, except the interrupt, follow nxt_state so each one comes straight from a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= abmrs_pkg::ABMRS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // loaded on entering the strobe state; sets the least strobe low time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= abmrs_pkg::RST_CNT;
      end else if (nxt_state == abmrs_pkg::ABMRS_STROBE
                   && state_ff != abmrs_pkg::ABMRS_STROBE) begin
         cnt_ff <= abmrs_pkg::STROBE_LOW_CNT - 4'h1;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end

   // ------------------------------------------------------------
   // request and grant acknowledge pins
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_req_n_o  <= abmrs_pkg::RST_HIGH;
         bus_req_n_oe <= abmrs_pkg::RST_LOW;
      end else begin
         // open drain: drive low while requesting, else float
         // released on the edge that takes the bus, never driven high
         bus_req_n_o  <= 1'b0;
         bus_req_n_oe <= (nxt_state == abmrs_pkg::ABMRS_REQ);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         grant_ack_n_o  <= abmrs_pkg::RST_HIGH;
         grant_ack_n_oe <= abmrs_pkg::RST_LOW;
      end else begin
         // held from ownership until the last cycle's strobe has risen
         grant_ack_n_o  <= !owns_bus(nxt_state);
         grant_ack_n_oe <= owns_bus(nxt_state);
      end
   end

   // ------------------------------------------------------------
   // bus drivers
   // ------------------------------------------------------------
   // strobe, direction and address pads drive only during tenure,
   // so a foreign master never meets a second driver
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_drive_oe <= abmrs_pkg::RST_LOW;
      end else begin
         bus_drive_oe <= owns_bus(nxt_state);
      end
   end

   // ------------------------------------------------------------
   // address, direction and strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_o              <= abmrs_pkg::RST_ADDR;
         mem_dir_read_high_o <= abmrs_pkg::RST_HIGH;
      end else if (nxt_state == abmrs_pkg::ABMRS_SETUP) begin
         // latched one cycle before the strobe falls, held for the cycle
         addr_o              <= xfer_addr;
         mem_dir_read_high_o <= xfer_read;
      end
   end

   // last flag picked up with the address, so a late change of
   // xfer_last cannot cut short a cycle that has already started
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_ff <= abmrs_pkg::RST_LOW;
      end else if (nxt_state == abmrs_pkg::ABMRS_SETUP) begin
         last_ff <= xfer_last;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_strobe_n_o <= abmrs_pkg::RST_HIGH;
      end else begin
         // low only in the strobe state; leaving it raises the strobe
         addr_strobe_n_o <= (nxt_state != abmrs_pkg::ABMRS_STROBE);
      end
   end

   // one-cycle pulse once the cycle has terminated
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xfer_done <= abmrs_pkg::RST_LOW;
      end else begin
         xfer_done <= (nxt_state == abmrs_pkg::ABMRS_END);
      end
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_n_o  <= abmrs_pkg::RST_HIGH;
         int_n_oe <= abmrs_pkg::RST_LOW;
      end else begin
         // open drain like the request: pad only sinks, mask gates each source
         int_n_o  <= 1'b0;
         int_n_oe <= |(irq_status & irq_mask);
      end
   end
endmodule

// >>> verification/abmrs_checker.sv
// assertions on the bus master ports
// assumes one clock domain, reset asynchronous and active low
module abmrs_checker (
   input wire logic        clk, rst_n, bus_protocol_select, bus_grant_n,
   input wire logic        addr_strobe_n_in, grant_ack_n_in, size_ack_lo_n, size_ack_hi_n,
   input wire logic [7:0]  irq_status, irq_mask,
   input wire logic        bus_req_n_o, bus_req_n_oe, grant_ack_n_o, grant_ack_n_oe,
   input wire logic        addr_strobe_n_o, mem_dir_read_high_o, bus_drive_oe, int_n_oe,
   input wire logic [31:0] addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic pend = |(irq_status & irq_mask);
   wire logic free = addr_strobe_n_in & grant_ack_n_in & size_ack_lo_n & size_ack_hi_n;
   wire logic may_own = !bus_grant_n && free;
   strobe_start_a: assert property ($fell(addr_strobe_n_o) |-> $past(bus_drive_oe))
      else $error("strobe fell before bus owned");
   strobe_end_a: assert property ((!addr_strobe_n_o)[*2] ##0 !(size_ack_lo_n | size_ack_hi_n)
      |=> addr_strobe_n_o) else $error("strobe not raised after ack");
   dir_hold_a: assert property (!addr_strobe_n_o |-> $stable(mem_dir_read_high_o)
      && $stable(addr_o)) else $error("direction or address moved in cycle");
   int_on_a: assert property (pend |=> int_n_oe) else $error("interrupt missing");
   int_off_a: assert property (!pend |=> !int_n_oe) else $error("masked interrupt");
   req_low_a: assert property (bus_req_n_oe |-> !bus_req_n_o)
      else $error("request driven high");
   own_cond_a: assert property ($rose(grant_ack_n_oe) |-> $past(may_own)
      && !grant_ack_n_o) else $error("ownership taken on busy bus");
   drop_req_a: assert property (grant_ack_n_oe |-> !bus_req_n_oe)
      else $error("request held while owning");
   mode_off_a: assert property (!bus_protocol_select && !bus_req_n_oe |=> !bus_req_n_oe)
      else $error("request in other protocol");
   cover property ($fell(addr_strobe_n_o));
   cover property ($rose(int_n_oe));
   cover property ($fell(grant_ack_n_oe));
endmodule
bind abmrs_master abmrs_checker chk (.clk, .rst_n, .bus_protocol_select, .bus_grant_n,
   .addr_strobe_n_in, .grant_ack_n_in, .size_ack_lo_n, .size_ack_hi_n, .irq_status,
   .irq_mask, .bus_req_n_o, .bus_req_n_oe, .grant_ack_n_o, .grant_ack_n_oe,
   .addr_strobe_n_o, .mem_dir_read_high_o, .bus_drive_oe, .int_n_oe, .addr_o);

// >>> verification/abmrs_partner.sv
// arbiter and slave model facing the bus master
// assumes pull-ups on strobe, grant acknowledge and size acknowledges
module abmrs_partner (
   input wire logic       clk, rst_n, bus_req_n_oe, grant_ack_n_oe, grant_ack_n_o,
   input wire logic       addr_strobe_n_o, bus_drive_oe, other_strobe_n,
   input wire logic [3:0] ack_wait,
   output logic           bus_grant_n, addr_strobe_n_in, grant_ack_n_in,
   output logic           size_ack_lo_n, size_ack_hi_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_ff;
   // released lines float to the pull-up level
   assign addr_strobe_n_in = other_strobe_n & (bus_drive_oe ? addr_strobe_n_o : 1'b1);
   assign grant_ack_n_in = grant_ack_n_oe ? grant_ack_n_o : 1'b1;
   assign size_ack_hi_n = size_ack_lo_n;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_grant_n <= 1'b1;
         wait_ff <= 4'h0;
         size_ack_lo_n <= 1'b1;
      end else begin
         bus_grant_n <= !bus_req_n_oe; // grant follows request, not ownership
         wait_ff <= addr_strobe_n_in ? 4'h0 : wait_ff + 4'h1;
         size_ack_lo_n <= addr_strobe_n_in | (wait_ff < ack_wait);
      end
   end
endmodule

// >>> verification/abmrs_master_test.sv
// self-checking bench for the bus master block
// assumes the partner model acts as arbiter and slave
module abmrs_master_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, bus_protocol_select = 1, xfer_req = 0, xfer_read = 0;
   logic xfer_last = 1, other_strobe_n = 1;
   logic [31:0] xfer_addr = '0, addr_o;
   logic [7:0] irq_status = '0, irq_mask = '0;
   logic [3:0] ack_wait = '0;
   logic bus_grant_n, addr_strobe_n_in, grant_ack_n_in, size_ack_lo_n, size_ack_hi_n;
   logic bus_req_n_o, bus_req_n_oe, grant_ack_n_o, grant_ack_n_oe, addr_strobe_n_o;
   logic mem_dir_read_high_o, bus_drive_oe, int_n_o, int_n_oe, xfer_done;
   int errors = 0, checked = 0;
   typedef struct packed {logic r; logic [31:0] a; logic [7:0] s, m; logic x; logic [3:0] w;}
      abmrs_row_t;
   abmrs_row_t rows [4] = '{'{1, 32'h0000_0010, 8'h01, 8'h01, 1, 4'h0},
      '{0, 32'hffff_fffc, 8'h80, 8'h7f, 0, 4'h3}, '{1, 32'h8000_0000, 8'h00, 8'hff, 0, 4'h1},
      '{0, 32'h1234_5678, 8'hff, 8'h80, 1, 4'h0}};
   abmrs_master dut (.clk, .rst_n, .bus_protocol_select, .xfer_req, .xfer_read, .xfer_addr,
      .xfer_last, .bus_grant_n, .addr_strobe_n_in, .grant_ack_n_in, .size_ack_lo_n,
      .size_ack_hi_n, .irq_status, .irq_mask, .bus_req_n_o, .bus_req_n_oe, .grant_ack_n_o,
      .grant_ack_n_oe, .addr_strobe_n_o, .mem_dir_read_high_o, .addr_o, .bus_drive_oe,
      .int_n_o, .int_n_oe, .xfer_done);
   abmrs_partner far (.clk, .rst_n, .bus_req_n_oe, .grant_ack_n_oe, .grant_ack_n_o,
      .addr_strobe_n_o, .bus_drive_oe, .other_strobe_n, .ack_wait, .bus_grant_n,
      .addr_strobe_n_in, .grant_ack_n_in, .size_ack_lo_n, .size_ack_hi_n);
   initial begin
      forever #5 clk = ~clk;
   end
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // bounded wait so a stuck handshake shows as a mismatch
   task automatic wt(ref logic s, input logic v);
      for (int n = 0; n < 60 && s !== v; n++) tick(1);
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (e !== s) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task conclude;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #50000;
      errors++;
      conclude();
   end
   // --------------------------------------------------------------
   // tests
   // --------------------------------------------------------------
   initial begin
      tick(10);
      rst_n = 1;
      chk("req_oe", 0, bus_req_n_oe);
      chk("strobe", 1, addr_strobe_n_o);
      chk("gack_rst0", 0, grant_ack_n_oe);
      $display("reset test done");
      foreach (rows[k]) begin
         {xfer_read, xfer_addr, irq_status, irq_mask, ack_wait} = {rows[k].r, rows[k].a,
            rows[k].s, rows[k].m, rows[k].w};
         xfer_req = 1;
         wt(addr_strobe_n_o, 0);
         xfer_req = 0;
         chk("addr", rows[k].a, addr_o);
         chk("dir", rows[k].r, mem_dir_read_high_o);
         chk("drive", 1, bus_drive_oe);
         chk("gack_o", 0, grant_ack_n_o);
         chk("int_pin", 0, int_n_o);
         wt(xfer_done, 1);
         chk("done", 1, xfer_done);
         chk("int", rows[k].x, int_n_oe);
         tick(3);
         chk("gack_oe", 0, grant_ack_n_oe);
         chk("drive_end", 0, bus_drive_oe);
         $display("row %0d done", k);
      end
      // foreign strobe holds off ownership, then two back-to-back cycles
      {other_strobe_n, xfer_last, xfer_req} = 3'b001;
      tick(10);
      chk("gack_busy", 0, grant_ack_n_oe);
      other_strobe_n = 1;
      wt(grant_ack_n_oe, 1);
      chk("req_drop", 0, bus_req_n_oe);
      wt(addr_strobe_n_o, 0);
      xfer_last = 1;
      wt(xfer_done, 1);
      tick(1);
      wt(addr_strobe_n_o, 0);
      chk("strobe2", 0, addr_strobe_n_o);
      xfer_req = 0;
      wt(xfer_done, 1);
      tick(3);
      chk("gack_end", 0, grant_ack_n_oe);
      $display("busy bus test done");
      // reset in mid-cycle drops the bus at once, then a fresh tenure
      {ack_wait, xfer_last, xfer_req} = {4'h3, 2'b11};
      wt(addr_strobe_n_o, 0);
      rst_n = 0;
      tick(2);
      chk("strobe_rst", 1, addr_strobe_n_o);
      chk("drive_rst", 0, bus_drive_oe);
      chk("gack_rst", 0, grant_ack_n_oe);
      rst_n = 1;
      wt(xfer_done, 1);
      xfer_req = 0;
      chk("done_rst", 1, xfer_done);
      $display("mid-run reset test done");
      {bus_protocol_select, xfer_req} = 2'b01;
      tick(20);
      chk("req_mode0", 0, bus_req_n_oe);
      chk("gack_mode0", 0, grant_ack_n_oe);
      xfer_req = 0;
      $display("protocol select test done");
      conclude();
   end
endmodule
